// [rtl/dlpl_top.sv]
// What this block does
// - sixteen-bit register at offset e8, reads 3f24 after reset.
// - bits 15:14 and 7:6 read zero, writes to them ignored.
// - writable endpoint fast-idle accept latency in 13:11, mirrored to device caps.
// - fast-idle accept code: 000 under 64 ns, doubling ranges, 111 default.
// - writable endpoint deep-idle accept latency in 10:8, mirrored to device caps.
// - deep-idle accept code: 000 under 1 us, doubling, 111 default.
// - writable fast-idle wakeup latency in 5:3, mirrored to link caps.
// - fast-idle wakeup code uses fast-idle ranges, default 100.
// - both accept fields load from eeprom, return to defaults on reset.
// - settings apply to all downstream ports, upstream port untouched.
// - writable deep-idle wakeup latency in 2:0, default 100, feeds link caps.
`timescale 1ns/10ps
`default_nettype none
`include "dlpl_regs.svh"
module dlpl_top (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire dlpl_pkg::dlpl_cfg_req_t cfg_req_i,
  input wire dlpl_pkg::dlpl_eeprom_t eeprom_i,
  output logic [15:0] cfg_rdata_o,
  output logic cfg_ack_o,
  output logic cfg_hit_o,
  output dlpl_pkg::dlpl_lat_t ds_lat_o
);
  import dlpl_pkg::*;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic [15:0] merge_be(input logic [15:0] old_v, input logic [15:0] new_v,
                                           input logic [1:0] be);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & `DLPL_WMASK;
    merge_be = (old_v & ~m) | (new_v & m);
  endfunction

  logic hit;
  logic wr_hit;
  logic [15:0] cur;
  logic [15:0] wv;
  logic [15:0] lv;
  dlpl_code_t ep_l0s;
  dlpl_code_t ep_l1;
  dlpl_code_t l0s_wk;
  dlpl_code_t l1_wk;

  assign hit = (cfg_req_i.addr == `DLPL_OFFSET);
  assign wr_hit = hit && cfg_req_i.wr;
  // reserved bits held at zero in the image
  assign cur = {2'h0, ep_l0s, ep_l1, 2'h0, l0s_wk, l1_wk};
  assign wv = merge_be(cur, cfg_req_i.wdata, cfg_req_i.be);
  assign lv = eeprom_i.data & `DLPL_WMASK;

  // ----------------------------------------
  // fields
  // ----------------------------------------
  // accept fields take the eeprom image; wakeup fields are software only
  dlpl_field u_ep_l0s (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .default_i(`DLPL_ACC_DEFAULT),
    .wr_i(wr_hit),
    .wdata_i(wv[`DLPL_EP_L0S_HI:`DLPL_EP_L0S_LO]),
    .load_i(eeprom_i.valid),
    .ldata_i(lv[`DLPL_EP_L0S_HI:`DLPL_EP_L0S_LO]),
    .code_o(ep_l0s)
  );
  dlpl_field u_ep_l1 (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .default_i(`DLPL_ACC_DEFAULT),
    .wr_i(wr_hit),
    .wdata_i(wv[`DLPL_EP_L1_HI:`DLPL_EP_L1_LO]),
    .load_i(eeprom_i.valid),
    .ldata_i(lv[`DLPL_EP_L1_HI:`DLPL_EP_L1_LO]),
    .code_o(ep_l1)
  );
  dlpl_field u_l0s_wk (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .default_i(`DLPL_EXIT_DEFAULT),
    .wr_i(wr_hit),
    .wdata_i(wv[`DLPL_L0S_EXIT_HI:`DLPL_L0S_EXIT_LO]),
    .load_i(1'b0),
    .ldata_i(3'h0),
    .code_o(l0s_wk)
  );
  dlpl_field u_l1_wk (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .default_i(`DLPL_EXIT_DEFAULT),
    .wr_i(wr_hit),
    .wdata_i(wv[`DLPL_L1_EXIT_HI:`DLPL_L1_EXIT_LO]),
    .load_i(1'b0),
    .ldata_i(3'h0),
    .code_o(l1_wk)
  );

  // ----------------------------------------
  // read response and mirror outputs
  // ----------------------------------------
  dlpl_state_t state;
  dlpl_state_t next_state;
  logic [15:0] next_rdata;
  logic next_hit;
  dlpl_lat_t next_lat;

  always_comb begin
    next_state = state;
    next_rdata = cfg_rdata_o;
    next_hit = cfg_hit_o;
    // one shared copy feeds every downstream port; upstream not wired here
    next_lat = '{ep_l0s_accept: ep_l0s, ep_l1_accept: ep_l1,
                 l0s_wakeup: l0s_wk, l1_wakeup: l1_wk};
    case (state)
      DLPL_IDLE: begin
        if (cfg_req_i.rd || cfg_req_i.wr) begin
          next_state = DLPL_RESP;
          next_hit = hit;
          // unmapped reads answer zero
          next_rdata = (hit && cfg_req_i.rd) ? cur : 16'h0000;
        end
      end
      DLPL_RESP: begin
        next_state = DLPL_IDLE;
        next_rdata = 16'h0000;
        next_hit = 1'b0;
      end
      default: begin
        next_state = DLPL_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state <= DLPL_IDLE;
      cfg_rdata_o <= 16'h0000;
      cfg_hit_o <= 1'b0;
      ds_lat_o <= `DLPL_LAT_RESET;
    end else begin
      state <= next_state;
      cfg_rdata_o <= next_rdata;
      cfg_hit_o <= next_hit;
      ds_lat_o <= next_lat;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cfg_ack_o <= 1'b0;
    end else begin
      cfg_ack_o <= (state == DLPL_IDLE) && (cfg_req_i.rd || cfg_req_i.wr);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_reset_value;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    $rose(resetn_i) |-> cur == `DLPL_RESET;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("bad reset value");

  property p_rsvd_zero;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    cfg_ack_o |-> cfg_rdata_o[15:14] == 2'h0 && cfg_rdata_o[7:6] == 2'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");

  property p_wr_l0s;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (wr_hit && cfg_req_i.be[1] && !eeprom_i.valid) |=> ep_l0s == $past(cfg_req_i.wdata[13:11]);
  endproperty
  a_wr_l0s: assert property (p_wr_l0s) else $error("accept fast write lost");

  property p_wr_l1;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (wr_hit && cfg_req_i.be[1] && !eeprom_i.valid) |=> ep_l1 == $past(cfg_req_i.wdata[10:8]);
  endproperty
  a_wr_l1: assert property (p_wr_l1) else $error("accept deep write lost");

  property p_wr_l0s_wk;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (wr_hit && cfg_req_i.be[0]) |=> l0s_wk == $past(cfg_req_i.wdata[5:3]);
  endproperty
  a_wr_l0s_wk: assert property (p_wr_l0s_wk) else $error("fast wakeup write lost");

  property p_wr_l1_wk;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (wr_hit && cfg_req_i.be[0]) |=> l1_wk == $past(cfg_req_i.wdata[2:0]);
  endproperty
  a_wr_l1_wk: assert property (p_wr_l1_wk) else $error("deep wakeup write lost");

  property p_eeprom;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    eeprom_i.valid |=> ep_l0s == $past(eeprom_i.data[13:11]) && ep_l1 == $past(eeprom_i.data[10:8]);
  endproperty
  a_eeprom: assert property (p_eeprom) else $error("eeprom load lost");

  property p_mirror;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    ##1 ds_lat_o == {$past(ep_l0s), $past(ep_l1), $past(l0s_wk), $past(l1_wk)};
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror mismatch");

  property p_readback;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (state == DLPL_IDLE && hit && cfg_req_i.rd && !cfg_req_i.wr) |=> cfg_ack_o && cfg_rdata_o == $past(cur);
  endproperty
  a_readback: assert property (p_readback) else $error("read data wrong");

  // ----------------------------------------
  // handshake, hold and reset default checks
  // ----------------------------------------
  property p_take;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (state == DLPL_IDLE && (cfg_req_i.rd || cfg_req_i.wr)) |=> cfg_ack_o;
  endproperty
  a_take: assert property (p_take) else $error("request not answered");

  property p_refuse;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (state == DLPL_RESP) |=> !cfg_ack_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("back to back request answered");

  property p_ack_pulse;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    cfg_ack_o |=> !cfg_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");

  property p_hit_ack;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    cfg_hit_o |-> cfg_ack_o;
  endproperty
  a_hit_ack: assert property (p_hit_ack) else $error("hit without ack");

  // idle data bus stays quiet so a stray sample reads zero
  property p_rdata_idle;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    !cfg_ack_o |-> cfg_rdata_o == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside ack");

  property p_unmapped;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (state == DLPL_IDLE && cfg_req_i.rd && !hit) |=> !cfg_hit_o && cfg_rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");

  property p_lane_hi_hold;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (wr_hit && !cfg_req_i.be[1] && !eeprom_i.valid) |=> ep_l0s == $past(ep_l0s) && ep_l1 == $past(ep_l1);
  endproperty
  a_lane_hi_hold: assert property (p_lane_hi_hold) else $error("upper lane changed");

  property p_lane_lo_hold;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (wr_hit && !cfg_req_i.be[0]) |=> l0s_wk == $past(l0s_wk) && l1_wk == $past(l1_wk);
  endproperty
  a_lane_lo_hold: assert property (p_lane_lo_hold) else $error("lower lane changed");

  // wakeup codes are software only, the loader must not touch them
  property p_wake_no_load;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (eeprom_i.valid && !wr_hit) |=> l0s_wk == $past(l0s_wk) && l1_wk == $past(l1_wk);
  endproperty
  a_wake_no_load: assert property (p_wake_no_load) else $error("wakeup loaded");

  property p_lat_reset;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    $rose(resetn_i) |-> ds_lat_o == `DLPL_LAT_RESET;
  endproperty
  a_lat_reset: assert property (p_lat_reset) else $error("mirror reset wrong");

  property p_fields_hold;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    (!wr_hit && !eeprom_i.valid) |=> cur == $past(cur);
  endproperty
  a_fields_hold: assert property (p_fields_hold) else $error("field changed unasked");

  property p_acc_default;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    $rose(resetn_i) |-> ep_l0s == `DLPL_ACC_DEFAULT && ep_l1 == `DLPL_ACC_DEFAULT;
  endproperty
  a_acc_default: assert property (p_acc_default) else $error("accept default wrong");

  property p_exit_default;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    $rose(resetn_i) |-> l0s_wk == `DLPL_EXIT_DEFAULT && l1_wk == `DLPL_EXIT_DEFAULT;
  endproperty
  a_exit_default: assert property (p_exit_default) else $error("wakeup default wrong");

  property p_deep_default;
    @(posedge ref_clk_i) disable iff (!resetn_i)
    $rose(resetn_i) |-> ep_l1 == `DLPL_ACC_DEFAULT;
  endproperty
  a_deep_default: assert property (p_deep_default) else $error("deep accept default wrong");

  c_write: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) wr_hit);
  c_read: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) hit && cfg_req_i.rd);
  c_load: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) eeprom_i.valid);
  c_collide: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) eeprom_i.valid && wr_hit);
  c_unmapped: cover property (@(posedge ref_clk_i) disable iff (!resetn_i) cfg_req_i.rd && !hit);
endmodule
`default_nettype wire

// [rtl/dlpl_regs.svh]
`ifndef DLPL_REGS_SVH
`define DLPL_REGS_SVH
`define DLPL_OFFSET 8'he8
`define DLPL_RESET 16'h3f24
`define DLPL_WMASK 16'h3f3f
`define DLPL_EP_L0S_HI 13
`define DLPL_EP_L0S_LO 11
`define DLPL_EP_L1_HI 10
`define DLPL_EP_L1_LO 8
`define DLPL_L0S_EXIT_HI 5
`define DLPL_L0S_EXIT_LO 3
`define DLPL_L1_EXIT_HI 2
`define DLPL_L1_EXIT_LO 0
`define DLPL_ACC_DEFAULT 3'h7
`define DLPL_EXIT_DEFAULT 3'h4
`define DLPL_LAT_RESET 12'hfe4
`endif

// [rtl/dlpl_pkg.sv]
package dlpl_pkg;
  typedef logic [2:0] dlpl_code_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [1:0] be;
    logic wr;
    logic rd;
  } dlpl_cfg_req_t;
  typedef struct packed {
    dlpl_code_t ep_l0s_accept;
    dlpl_code_t ep_l1_accept;
    dlpl_code_t l0s_wakeup;
    dlpl_code_t l1_wakeup;
  } dlpl_lat_t;
  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } dlpl_eeprom_t;
  typedef enum logic [0:0] {
    DLPL_IDLE = 1'b0,
    DLPL_RESP = 1'b1
  } dlpl_state_t;
endpackage

// [rtl/dlpl_field.sv]
`timescale 1ns/10ps
`default_nettype none
// one three-bit latency code with default, cfg write and eeprom load
module dlpl_field (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [2:0] default_i,
  input wire logic wr_i,
  input wire logic [2:0] wdata_i,
  input wire logic load_i,
  input wire logic [2:0] ldata_i,
  output logic [2:0] code_o
);
  logic [2:0] next_code;
  always_comb begin
    next_code = code_o;
    // eeprom load wins: it runs before software owns the space
    if (load_i) begin
      next_code = ldata_i;
    end else if (wr_i) begin
      next_code = wdata_i;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      code_o <= default_i;
    end else begin
      code_o <= next_code;
    end
  end
endmodule
`default_nettype wire

// [verification/downstream_link_pm_latency_reg_bench.sv]
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// bench for the downstream latency register
// ----------------------------------------
module downstream_link_pm_latency_reg_bench;
  import dlpl_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn;
  dlpl_cfg_req_t cfg_req;
  dlpl_eeprom_t eeprom;
  logic [15:0] cfg_rdata;
  logic cfg_ack;
  logic cfg_hit;
  dlpl_lat_t ds_lat;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  dlpl_top uut (
    .ref_clk_i(ref_clk),
    .resetn_i(resetn),
    .cfg_req_i(cfg_req),
    .eeprom_i(eeprom),
    .cfg_rdata_o(cfg_rdata),
    .cfg_ack_o(cfg_ack),
    .cfg_hit_o(cfg_hit),
    .ds_lat_o(ds_lat)
  );

  always #5 ref_clk = ~ref_clk;

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task end_sim();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // hang guard, tests need about eighty cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 2000) begin
      num_errors++;
      end_sim();
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task do_reset();
    @(negedge ref_clk);
    resetn = 1'b0;
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
  endtask

  // request held one edge, answer looked at in its single ack cycle
  task cfg(input logic w, input logic [7:0] a, input logic [15:0] d, input logic [1:0] b,
           input logic [15:0] exp, input logic hit);
    @(negedge ref_clk);
    cfg_req = {a, d, b, w, ~w};
    @(negedge ref_clk);
    chk({15'h0, cfg_ack}, 16'h1);
    chk({15'h0, cfg_hit}, {15'h0, hit});
    chk(cfg_rdata, exp);
    cfg_req = '0;
  endtask

  task rd(input logic [7:0] a, input logic [15:0] exp, input logic hit);
    cfg(1'b0, a, 16'h0, 2'b00, exp, hit);
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] b);
    cfg(1'b1, a, d, b, 16'h0, a == 8'he8);
  endtask

  // mirror lands one edge after the write edge
  task lat(input logic [11:0] exp);
    @(negedge ref_clk);
    chk({4'h0, ds_lat}, {4'h0, exp});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset();
    do_reset();
    rd(8'he8, 16'h3f24, 1'b1);
    lat(12'hfe4);
    $display("test reset done");
  endtask

  task t_codes();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = i[2:0];
      wr(8'he8, {2'b11, c, c, 2'b11, c, c}, 2'b11);
      lat({c, c, c, c});
      rd(8'he8, {2'b00, c, c, 2'b00, c, c}, 1'b1);
    end
    $display("test codes done");
  endtask

  task t_lanes();
    wr(8'he8, 16'h0000, 2'b01);
    rd(8'he8, 16'h3f00, 1'b1);
    wr(8'he8, 16'h0000, 2'b10);
    wr(8'he8, 16'hffff, 2'b00);
    rd(8'he8, 16'h0000, 1'b1);
    $display("test lanes done");
  endtask

  task t_unmapped();
    rd(8'he4, 16'h0000, 1'b0);
    wr(8'hea, 16'hffff, 2'b11);
    rd(8'he8, 16'h0000, 1'b1);
    $display("test unmapped done");
  endtask

  task t_eeprom();
    @(negedge ref_clk);
    eeprom = {1'b1, 16'h1100};
    @(negedge ref_clk);
    eeprom = '0;
    rd(8'he8, 16'h1100, 1'b1);
    // loader wins the accept fields over a same-cycle write
    @(negedge ref_clk);
    cfg_req = {8'he8, 16'h3f3f, 2'b11, 1'b1, 1'b0};
    eeprom = {1'b1, 16'h2a00};
    @(negedge ref_clk);
    chk({15'h0, cfg_ack}, 16'h1);
    cfg_req = '0;
    eeprom = '0;
    rd(8'he8, 16'h2a3f, 1'b1);
    do_reset();
    rd(8'he8, 16'h3f24, 1'b1);
    lat(12'hfe4);
    $display("test eeprom done");
  endtask

  initial begin
    cfg_req = '0;
    eeprom = '0;
    resetn = 1'b0;
    t_reset();
    t_codes();
    t_lanes();
    t_unmapped();
    t_eeprom();
    end_sim();
  end
endmodule
`default_nettype wire
